// ### inc/kwsm_pkg.sv
// Purpose: Shared constants for the keyboard wake scan matcher
// Assumes: 125 MHz system clock, runtime register offsets as byte addresses
// Notes: Long counts are also top-level parameters so a bench can shorten them
package kwsm_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_MAKE_FIRST = 8'h5f;
   localparam logic [7:0] OFS_MAKE_SECOND = 8'h60;
   localparam logic [7:0] OFS_BREAK_CODE = 8'h61;
   localparam logic [7:0] OFS_STATUS_CTRL = 8'h64;
   // ----------------------------------------------------------------
   // Status/control field positions and reset values
   // ----------------------------------------------------------------
   localparam int BIT_WAKE_STICKY = 0;
   localparam int BIT_DISABLE = 1;
   localparam int BIT_SCAN_LO = 2;
   localparam int BIT_SCAN_HI = 3;
   localparam int BIT_REL_LO = 4;
   localparam int BIT_REL_HI = 5;
   localparam int BIT_ANY_BREAK = 6;
   localparam logic [7:0] RST_MAKE = 8'h00;
   localparam logic [7:0] RST_BREAK = 8'h00;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] CTRL_WMASK = 8'h7e;
   // ----------------------------------------------------------------
   // Scan code constants
   // ----------------------------------------------------------------
   localparam logic [7:0] WILDCARD = 8'h00;
   localparam logic [7:0] CODE_EXT = 8'he0;
   localparam logic [7:0] CODE_REL = 8'hf0;
   localparam logic [3:0] FRAME_LAST = 4'ha;
   // ----------------------------------------------------------------
   // Release options
   // ----------------------------------------------------------------
   localparam logic [1:0] REL_PULSE = 2'b00;
   localparam logic [1:0] REL_NOT_MAKE = 2'b01;
   localparam logic [1:0] REL_BREAK = 2'b10;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int TIMEOUT_US = 125;
   localparam int PULSE_MS = 500;
   localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
   localparam int PULSE_CYC = PULSE_MS * 1000 * CLK_MHZ;
endpackage : kwsm_pkg

// ### rtl/kwsm_matcher.sv
// Purpose: Snoops keyboard clock/data and raises a wake event on a programmed make code
// Assumes: Keyboard lines are asynchronous; register port is on clk
// Notes: Match is decided when the stop bit is sampled, one keyboard clock after clock 10
`timescale 1ns/1ps

// Operation
// - Single-byte select compares each valid byte with first make byte.
// - A make byte of zero matches any valid received byte.
// - Two-byte select needs first then second make byte on consecutive bytes.
// - Mismatch, parity error or timeout restarts search at first byte.
// - Keyboard clock stuck 125 us mid-byte abandons decode and frame.
// - Sticky wake status bit drives active-low wake output while in sleep.
// - Status bits five and four select the release behaviour.
// - Withdrawing the event leaves the sticky wake status bit set.
// - Option 00 gives a 0.5 s pulse, no new event meanwhile.
// - Option 01 holds event until a valid non-matching code arrives.
// - Valid single byte: parity good; two-byte also needs first byte match.
// - Option 10 holds event until a valid break code arrives.
// - Break code is either the programmed one or any valid break.
// - Data plus parity must hold odd ones, else byte invalid.
// - Disable bit high stops matcher; reset value zero keeps it running.
// - Wake event raised well within 100 us of clock ten.
module kwsm_matcher #(
   parameter int TIMEOUT_CYCLES = kwsm_pkg::TIMEOUT_CYC,
   parameter int PULSE_CYCLES = kwsm_pkg::PULSE_CYC
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic keyboardClockLine,
   input wire logic keyboardDataLine,
   input wire logic sleepState,
   input wire logic [7:0] regAddr,
   input wire logic regWrite,
   input wire logic [7:0] regWData,
   output logic [7:0] regRData,
   output logic keyWakeStatusEventN,
   output logic wakeOutputN
);
   // Refuse counts that the timers cannot serve
   if (TIMEOUT_CYCLES < 2 || PULSE_CYCLES < 2) begin : g_badCount
      $error("kwsm_matcher: counts must be at least 2");
   end

   typedef enum logic {DEC_FIRST, DEC_SECOND} kwsm_dec_t;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [1:0] lineClkSync_r, kdatSync_r;
   logic lineClkPrev_r;
   // Two flops per pin; previous level resets to idle high so no false edge follows reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lineClkSync_r <= 2'b11;
         kdatSync_r <= 2'b11;
         lineClkPrev_r <= 1'b1;
      end else begin
         lineClkSync_r <= {lineClkSync_r[0], keyboardClockLine};
         kdatSync_r <= {kdatSync_r[0], keyboardDataLine};
         lineClkPrev_r <= lineClkSync_r[1];
      end
   end
   wire lineClk = lineClkSync_r[1];
   wire kdat = kdatSync_r[1];
   wire fallEdge = lineClkPrev_r & ~lineClk;
   wire anyEdge = lineClkPrev_r ^ lineClk;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] makeFirst_r, makeFirst_nxt, makeSecond_r, makeSecond_nxt;
   logic [7:0] breakCode_r, breakCode_nxt, ctrl_r, ctrl_nxt, rdata_r, rdata_nxt;
   logic stickySet;
   wire disabled = ctrl_r[kwsm_pkg::BIT_DISABLE];
   wire twoByte = ctrl_r[kwsm_pkg::BIT_SCAN_LO];
   wire [1:0] relOpt = ctrl_r[kwsm_pkg::BIT_REL_HI:kwsm_pkg::BIT_REL_LO];
   wire anyBreak = ctrl_r[kwsm_pkg::BIT_ANY_BREAK];

   // Register writes; sticky status is write-one-to-clear and a new event wins
   always_comb begin
      makeFirst_nxt = makeFirst_r;
      makeSecond_nxt = makeSecond_r;
      breakCode_nxt = breakCode_r;
      ctrl_nxt = ctrl_r;
      if (regWrite) begin
         case (regAddr)
            kwsm_pkg::OFS_MAKE_FIRST: makeFirst_nxt = regWData;
            kwsm_pkg::OFS_MAKE_SECOND: makeSecond_nxt = regWData;
            kwsm_pkg::OFS_BREAK_CODE: breakCode_nxt = regWData;
            kwsm_pkg::OFS_STATUS_CTRL: begin
               ctrl_nxt = (regWData & kwsm_pkg::CTRL_WMASK) | (ctrl_r & ~kwsm_pkg::CTRL_WMASK);
               if (regWData[kwsm_pkg::BIT_WAKE_STICKY]) begin
                  ctrl_nxt[kwsm_pkg::BIT_WAKE_STICKY] = 1'b0;
               end
            end
            default: ;
         endcase
      end
      if (stickySet) begin
         ctrl_nxt[kwsm_pkg::BIT_WAKE_STICKY] = 1'b1;
      end
      case (regAddr)
         kwsm_pkg::OFS_MAKE_FIRST: rdata_nxt = makeFirst_r;
         kwsm_pkg::OFS_MAKE_SECOND: rdata_nxt = makeSecond_r;
         kwsm_pkg::OFS_BREAK_CODE: rdata_nxt = breakCode_r;
         kwsm_pkg::OFS_STATUS_CTRL: rdata_nxt = ctrl_r;
         default: rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         makeFirst_r <= kwsm_pkg::RST_MAKE;
         makeSecond_r <= kwsm_pkg::RST_MAKE;
         breakCode_r <= kwsm_pkg::RST_BREAK;
         ctrl_r <= kwsm_pkg::RST_CTRL;
         rdata_r <= 8'h00;
      end else begin
         makeFirst_r <= makeFirst_nxt;
         makeSecond_r <= makeSecond_nxt;
         breakCode_r <= breakCode_nxt;
         ctrl_r <= ctrl_nxt;
         rdata_r <= rdata_nxt;
      end
   end
   assign regRData = rdata_r;

   // ----------------------------------------------------------------
   // Frame receiver
   // ----------------------------------------------------------------
   logic [3:0] bitCnt_r, bitCnt_nxt;
   logic [8:0] shift_r, shift_nxt;
   logic [31:0] idle_r, idle_nxt;
   logic byteDone, byteGood, timeout;

   // Sample on falling edges; a stuck clock mid-frame times out
   always_comb begin
      bitCnt_nxt = bitCnt_r;
      shift_nxt = shift_r;
      idle_nxt = (anyEdge || bitCnt_r == 4'h0) ? 32'd0 : idle_r + 32'd1;
      byteDone = 1'b0;
      byteGood = 1'b0;
      timeout = (idle_r >= 32'(TIMEOUT_CYCLES - 1)) && !anyEdge && bitCnt_r != 4'h0;
      if (disabled || timeout) begin
         bitCnt_nxt = 4'h0;
         idle_nxt = 32'd0;
      end else if (fallEdge) begin
         if (bitCnt_r == 4'h0) begin
            bitCnt_nxt = kdat ? 4'h0 : 4'h1;
         end else if (bitCnt_r == kwsm_pkg::FRAME_LAST) begin
            bitCnt_nxt = 4'h0;
            byteDone = 1'b1;
            byteGood = kdat && (^shift_r);
         end else begin
            shift_nxt = {kdat, shift_r[8:1]};
            bitCnt_nxt = bitCnt_r + 4'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bitCnt_r <= 4'h0;
         shift_r <= 9'h000;
         idle_r <= 32'd0;
      end else begin
         bitCnt_r <= bitCnt_nxt;
         shift_r <= shift_nxt;
         idle_r <= idle_nxt;
      end
   end
   wire [7:0] rxByte = shift_r[7:0];

   // ----------------------------------------------------------------
   // Make decoder and release control
   // ----------------------------------------------------------------
   function automatic logic byteMatch(input logic [7:0] want, input logic [7:0] got);
      byteMatch = (want == kwsm_pkg::WILDCARD) || (want == got);
   endfunction : byteMatch

   kwsm_dec_t dec_r, dec_nxt;
   logic event_r, event_nxt, afterRel_r, afterRel_nxt;
   logic [31:0] pulse_r, pulse_nxt;
   logic eventN_r, wakeN_r;
   logic fullMatch, codeValid, breakSeen;

   always_comb begin
      dec_nxt = dec_r;
      event_nxt = event_r;
      afterRel_nxt = afterRel_r;
      pulse_nxt = pulse_r;
      fullMatch = 1'b0;
      codeValid = 1'b0;
      breakSeen = 1'b0;
      stickySet = 1'b0;
      if (event_r && !relOpt[0] == !relOpt[1] && pulse_r != 32'd0) begin
         pulse_nxt = pulse_r - 32'd1;
      end
      if (disabled) begin
         dec_nxt = DEC_FIRST;
         event_nxt = 1'b0;
         afterRel_nxt = 1'b0;
         pulse_nxt = 32'd0;
      end else if (timeout || (byteDone && !byteGood)) begin
         dec_nxt = DEC_FIRST;
         afterRel_nxt = 1'b0;
      end else if (byteDone) begin
         if (!twoByte) begin
            fullMatch = byteMatch(makeFirst_r, rxByte);
            codeValid = 1'b1;
            dec_nxt = DEC_FIRST;
         end else if (dec_r == DEC_FIRST) begin
            dec_nxt = byteMatch(makeFirst_r, rxByte) ? DEC_SECOND : DEC_FIRST;
         end else begin
            fullMatch = byteMatch(makeSecond_r, rxByte);
            codeValid = 1'b1;
            dec_nxt = DEC_FIRST;
         end
         if (anyBreak) begin
            breakSeen = afterRel_r || (rxByte[7] && rxByte != kwsm_pkg::CODE_EXT && rxByte != kwsm_pkg::CODE_REL);
         end else begin
            breakSeen = (rxByte == breakCode_r);
         end
         afterRel_nxt = (rxByte == kwsm_pkg::CODE_REL);
         if (!event_r) begin
            if (fullMatch) begin
               event_nxt = 1'b1;
               stickySet = 1'b1;
               pulse_nxt = 32'(PULSE_CYCLES - 1);
            end
         end else begin
            case (relOpt)
               kwsm_pkg::REL_NOT_MAKE: if (codeValid && !fullMatch) event_nxt = 1'b0;
               kwsm_pkg::REL_BREAK: if (breakSeen) event_nxt = 1'b0;
               default: ;
            endcase
         end
      end
      // options 00 and 11 use the timed pulse
      if (!disabled && event_r && relOpt[0] == relOpt[1] && pulse_r == 32'd0) begin
         event_nxt = 1'b0;
      end
   end

   // event registered one cycle after the stop bit sample
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dec_r <= DEC_FIRST;
         event_r <= 1'b0;
         afterRel_r <= 1'b0;
         pulse_r <= 32'd0;
         eventN_r <= 1'b1;
         wakeN_r <= 1'b1;
      end else begin
         dec_r <= dec_nxt;
         event_r <= event_nxt;
         afterRel_r <= afterRel_nxt;
         pulse_r <= pulse_nxt;
         eventN_r <= ~event_nxt;
         wakeN_r <= ~(ctrl_nxt[kwsm_pkg::BIT_WAKE_STICKY] && sleepState);
      end
   end
   assign keyWakeStatusEventN = eventN_r;
   assign wakeOutputN = wakeN_r;
endmodule : kwsm_matcher

// ### bench/kwsm_matcher_props.sv
// Purpose: Port-level checks for the wake scan matcher
// Assumes: Control writes are visible on the register port
// Notes: Shadows the control byte to know the release option
`timescale 1ns/1ps
module kwsm_matcher_props #(
   parameter int PULSE_CYCLES = 50
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic keyboardClockLine,
   input wire logic keyboardDataLine,
   input wire logic sleepState,
   input wire logic [7:0] regAddr,
   input wire logic regWrite,
   input wire logic [7:0] regWData,
   input wire logic [7:0] regRData,
   input wire logic keyWakeStatusEventN,
   input wire logic wakeOutputN
);
   // ----
   // Helper state
   // ----
   logic [7:0] ctrlSh_r, ctrlSh_nxt;
   int lowCnt_r, lowCnt_nxt;
   // Shadow control writes; count cycles the event stays low
   always_comb begin
      ctrlSh_nxt = (regWrite && regAddr == kwsm_pkg::OFS_STATUS_CTRL) ? regWData : ctrlSh_r;
      lowCnt_nxt = keyWakeStatusEventN ? 0 : lowCnt_r + 1;
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrlSh_r <= kwsm_pkg::RST_CTRL;
         lowCnt_r <= 0;
      end else begin
         ctrlSh_r <= ctrlSh_nxt;
         lowCnt_r <= lowCnt_nxt;
      end
   end
   default clocking dcb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence makeWrite;
      regWrite && regAddr == kwsm_pkg::OFS_MAKE_FIRST ##1 regAddr == kwsm_pkg::OFS_MAKE_FIRST;
   endsequence
   chk_out_sleep_only: assert property ($past(!sleepState) |-> wakeOutputN)
      else $error("wake output low outside sleep");
   chk_reset_idle: assert property ($rose(resetn) |-> regRData == 8'h00 && keyWakeStatusEventN && wakeOutputN)
      else $error("outputs not idle after reset");
   chk_unmapped_zero: assert property (!($past(regAddr) inside {8'h5f, 8'h60, 8'h61, 8'h64}) |-> regRData == 8'h00)
      else $error("unmapped read not zero");
   chk_ctrl_top_zero: assert property ($past(regAddr) == 8'h64 |-> !regRData[7])
      else $error("control bit 7 reads one");
   chk_make_readback: assert property (makeWrite |=> regRData == $past(regWData, 2))
      else $error("make byte readback wrong");
   chk_event_wakes: assert property (($fell(keyWakeStatusEventN) && sleepState) ##1 sleepState[*3] |-> !wakeOutputN)
      else $error("event did not reach wake output");
   chk_pulse_width: assert property ($rose(keyWakeStatusEventN) && ctrlSh_r[5] == ctrlSh_r[4] |-> lowCnt_r == PULSE_CYCLES)
      else $error("event pulse width wrong");
   chk_disabled_quiet: assert property (ctrlSh_r[1] && $past(ctrlSh_r[1], 3) |-> keyWakeStatusEventN)
      else $error("event while disabled");
endmodule : kwsm_matcher_props

bind kwsm_matcher kwsm_matcher_props #(.PULSE_CYCLES(PULSE_CYCLES)) i_props (.clk(clk), .resetn(resetn),
   .keyboardClockLine(keyboardClockLine), .keyboardDataLine(keyboardDataLine), .sleepState(sleepState),
   .regAddr(regAddr), .regWrite(regWrite), .regWData(regWData), .regRData(regRData),
   .keyWakeStatusEventN(keyWakeStatusEventN), .wakeOutputN(wakeOutputN));

// ### bench/kwsm_keyboard_model.sv
// Purpose: Behavioural serial keyboard
// Assumes: Both lines have pull-ups, so idle reads high
// Notes: 80 ns bit period; clock stands high between frames
`timescale 1ns/1ps
module kwsm_keyboard_model (
   output logic keyboardClockLine,
   output logic keyboardDataLine
);
   // ----
   // Frame sender
   // ----
   initial begin
      keyboardClockLine = 1'b1;
      keyboardDataLine = 1'b1;
   end
   // badPar flips parity; cutAt stalls the clock low after that bit
   task automatic send(input logic [7:0] b, input logic badPar, input int cutAt);
      logic [10:0] frm;
      frm = {1'b1, ~^b ^ badPar, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         keyboardDataLine = frm[i];
         #40 keyboardClockLine = 1'b0;
         if (i + 1 == cutAt) begin
            #400 break;
         end
         #40 keyboardClockLine = 1'b1;
      end
      keyboardClockLine = 1'b1;
      keyboardDataLine = 1'b1;
      #80;
   endtask : send
endmodule : kwsm_keyboard_model

// ### bench/kwsm_matcher_tb_top.sv
// Purpose: Self-checking bench for the wake scan matcher
// Assumes: Timeout shortened to 20 and pulse to 50 cycles
// Notes: Frames come from the keyboard model
`timescale 1ns/1ps
module kwsm_matcher_tb_top;
   localparam int PULSE = 50;
   logic clk, resetn, sleepState, regWrite, keyboardClockLine, keyboardDataLine, keyWakeStatusEventN, wakeOutputN;
   logic [7:0] regAddr, regWData, regRData;
   int errTotal, comparisons, cycles;
   kwsm_matcher #(.TIMEOUT_CYCLES(20), .PULSE_CYCLES(PULSE)) i_dut (.clk(clk), .resetn(resetn),
      .keyboardClockLine(keyboardClockLine), .keyboardDataLine(keyboardDataLine), .sleepState(sleepState),
      .regAddr(regAddr), .regWrite(regWrite), .regWData(regWData), .regRData(regRData),
      .keyWakeStatusEventN(keyWakeStatusEventN), .wakeOutputN(wakeOutputN));
   kwsm_keyboard_model i_kbd (.keyboardClockLine(keyboardClockLine), .keyboardDataLine(keyboardDataLine));
   // ----
   // Clock, watchdog and tasks
   // ----
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic wrapUp();
      if (errTotal == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrapUp
   // Cuts a hang short well past the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errTotal++;
         $display("ERROR %0t watchdog expired", $time);
         wrapUp();
      end
   end
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         errTotal++;
         $display("ERROR %0t read %h expected %h", $time, got, exp);
      end
   endtask : cmp8
   task automatic cmpb(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         errTotal++;
         $display("ERROR %0t flag %b expected %b", $time, got, exp);
      end
   endtask : cmpb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      regAddr <= a;
      repeat (2) @(posedge clk);
      #1 cmp8(regRData, exp);
   endtask : rd
   // Frames start on a falling clock edge so pin changes never race the samplers
   task automatic keyx(input logic [7:0] b, input logic badPar, input int cutAt);
      @(negedge clk);
      i_kbd.send(b, badPar, cutAt);
   endtask : keyx
   task automatic key(input logic [7:0] b);
      keyx(b, 1'b0, 0);
   endtask : key
   // Short settle after the last stop bit, then look at the event
   task automatic ev(input logic exp);
      repeat (8) @(posedge clk);
      #1 cmpb(keyWakeStatusEventN, exp);
   endtask : ev
   task automatic pulse();
      ev(1'b0);
      repeat (PULSE) @(posedge clk);
      #1 cmpb(keyWakeStatusEventN, 1'b1);
   endtask : pulse
   // ----
   // Main sequence
   // ----
   initial begin
      resetn = 1'b0;
      sleepState = 1'b1;
      regWrite = 1'b0;
      regAddr = 8'h00;
      regWData = 8'h00;
      errTotal = 0;
      comparisons = 0;
      cycles = 0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      rd(8'h5f, 8'h00);
      rd(8'h64, 8'h00);
      rd(8'h70, 8'h00);
      wr(8'h64, 8'hff);
      rd(8'h64, 8'h7e);
      key(8'h37);
      key(8'h38);
      ev(1'b1);
      wr(8'h64, 8'h00);
      wr(8'h5f, 8'h37);
      rd(8'h5f, 8'h37);
      key(8'h38);
      keyx(8'h37, 1'b1, 0);
      ev(1'b1);
      key(8'h37);
      pulse();
      cmpb(wakeOutputN, 1'b0);
      rd(8'h64, 8'h01);
      wr(8'h5f, 8'h00);
      wr(8'h64, 8'h31);
      rd(8'h64, 8'h30);
      cmpb(wakeOutputN, 1'b1);
      key(8'h5a);
      pulse();
      wr(8'h5f, 8'he0);
      wr(8'h60, 8'h37);
      wr(8'h64, 8'h15);
      key(8'h37);
      key(8'he0);
      key(8'h12);
      key(8'he0);
      keyx(8'h37, 1'b0, 4);
      key(8'h37);
      key(8'he0);
      keyx(8'h37, 1'b1, 0);
      ev(1'b1);
      key(8'he0);
      key(8'h37);
      ev(1'b0);
      key(8'he0);
      key(8'h37);
      ev(1'b0);
      key(8'he0);
      key(8'h12);
      ev(1'b1);
      wr(8'h61, 8'hb7);
      wr(8'h5f, 8'h37);
      wr(8'h64, 8'h21);
      key(8'h37);
      key(8'h85);
      ev(1'b0);
      @(posedge clk);
      sleepState <= 1'b0;
      repeat (3) @(posedge clk);
      #1 cmpb(wakeOutputN, 1'b1);
      @(posedge clk);
      sleepState <= 1'b1;
      key(8'hb7);
      ev(1'b1);
      wr(8'h64, 8'h69);
      key(8'h37);
      ev(1'b0);
      key(8'h85);
      ev(1'b1);
      wrapUp();
   end
endmodule : kwsm_matcher_tb_top
